/* File: shared/arsi_cfg.svh */
`ifndef ARSI_CFG_SVH
`define ARSI_CFG_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define ARSI_OFS_STATUS_CONTROL_ONE 8'h00
`define ARSI_OFS_STATUS_CONTROL_TWO 8'h04
`define ARSI_OFS_RESULT_HIGH        8'h08
`define ARSI_OFS_RESULT_LOW         8'h0C
`define ARSI_OFS_EVENT_STATUS       8'h10
`define ARSI_OFS_EVENT_MASK         8'h14

// ****************************************************************
// Field positions of the control registers
// ****************************************************************
`define ARSI_SC1_CHAN_MSB  4
`define ARSI_SC1_CHAN_LSB  0
`define ARSI_SC1_CONT_BIT  5
`define ARSI_SC1_IEN_BIT   6
`define ARSI_SC1_FLAG_BIT  7
`define ARSI_CHAN_OFF      5'h1F
`define ARSI_SC2_MODE_MSB  1
`define ARSI_SC2_MODE_LSB  0
`define ARSI_SC2_ACLK_BIT  2
`define ARSI_SC2_BUSY_BIT  7

// ****************************************************************
// Event status bits
// ****************************************************************
`define ARSI_EV_DONE_BIT    0
`define ARSI_EV_OVERRUN_BIT 1
`define ARSI_EV_WIDTH       2

// ****************************************************************
// Reset values, timing and bus responses
// ****************************************************************
`define ARSI_SC1_RESET     8'h1F
`define ARSI_SC2_RESET     8'h00
`define ARSI_MASK_RESET    2'h0
`define ARSI_GUARD_CYCLES  2'h3
`define ARSI_RESULT_WIDTH  12
`define ARSI_RESP_OKAY     2'h0
`define ARSI_RESP_SLVERR   2'h2

`endif

/* File: shared/arsi_pkg.sv */
package arsi_pkg;

  // Result resolution as set in status and control two
  typedef enum logic [1:0] {
    ARSI_RES_8  = 2'h0,
    ARSI_RES_10 = 2'h1,
    ARSI_RES_12 = 2'h2
  } arsi_res_e;

  // Conversion control states, one-hot
  typedef enum logic [2:0] {
    ARSI_ST_IDLE  = 3'b001,
    ARSI_ST_GUARD = 3'b010,
    ARSI_ST_CONV  = 3'b100
  } arsi_state_e;

endpackage : arsi_pkg

/* File: verilog/arsi_sync.sv */
`timescale 1ns/1ps

// Two-flop synchroniser for a bus of quasi-static levels
module arsi_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta; // First stage, read only by second stage

  // ****************************************************************
  // Two stages
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule : arsi_sync

/* File: verilog/arsi_coherent.sv */
`timescale 1ns/1ps
`include "arsi_cfg.svh"

// Result register with high-byte read freezing the low byte
module arsi_coherent (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic                          load,
  input  wire logic [`ARSI_RESULT_WIDTH-1:0] load_data,
  input  wire logic [1:0]                    mode,
  input  wire logic                          rd_high,
  input  wire logic                          rd_low,
  output logic      [7:0]                    high_byte,
  output logic      [7:0]                    low_byte
);

  logic [`ARSI_RESULT_WIDTH-1:0] result;    // Latest stored conversion
  logic [7:0]                    low_latch; // Low byte frozen by high read
  logic                          frozen;    // Low read must use the latch
  logic                          wide;      // 10 or 12 bit result mode

  assign wide = (mode != arsi_pkg::ARSI_RES_8);

  // ****************************************************************
  // Result storage
  // ****************************************************************
  // A load only ever touches the live result, never the latch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result <= '0;
    end else if (load) begin
      result <= load_data;
    end
  end

  // ****************************************************************
  // Low-byte freeze
  // ****************************************************************
  // Latch takes the value before a same-edge load,
  // so a coinciding completion cannot leak in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_latch <= 8'h00;
      frozen    <= 1'b0;
    end else if (rd_high && wide) begin
      low_latch <= result[7:0];
      frozen    <= 1'b1;
    end else if (rd_low) begin
      frozen    <= 1'b0;
    end
  end

  // ****************************************************************
  // Read views
  // ****************************************************************
  always_comb begin
    case (mode)
      arsi_pkg::ARSI_RES_10: high_byte = {6'h00, result[9:8]};
      arsi_pkg::ARSI_RES_12: high_byte = {4'h0, result[11:8]};
      default:               high_byte = 8'h00;
    endcase
    // Eight-bit mode gives the whole result in one byte
    if (!wide) begin
      low_byte = result[11:4];
    end else if (frozen) begin
      low_byte = low_latch;
    end else begin
      low_byte = result[7:0];
    end
  end

endmodule : arsi_coherent

/* File: verilog/arsi_top.sv */
`timescale 1ns/1ps
`include "arsi_cfg.svh"

// Summary of operation
// - High byte read freezes low byte outside eight-bit mode
// - Coinciding completion never overwrites frozen low byte
// - Eight-bit mode returns whole result at once
// - Single mode result held until next start
// - Completion sets flag and stores result
// - Control one write with lane zero strobe clears flag
// - Enabled flag raises interrupt request
// - Control one write selects channel and mode
// - Engine clock may be bus or asynchronous
module arsi_top (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]                    s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]                    s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  // Conversion engine
  output logic                               conv_start,
  output logic                               conv_abort,
  output logic [4:0]                         conv_channel,
  output logic [1:0]                         conv_mode,
  output logic                               conv_async_clk_sel,
  input  wire logic                          conv_done_tgl,
  input  wire logic [`ARSI_RESULT_WIDTH-1:0] conv_result,
  // Interrupt
  output logic                               irq
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [7:0]  aw_addr;          // Captured write address
  logic        aw_held;          // Write address waiting
  logic [31:0] w_data;           // Captured write data
  logic [3:0]  w_strb;           // Captured write strobes
  logic        w_held;           // Write data waiting
  logic        wr_go;            // Write performed this cycle
  logic        wr_lane0;         // Low byte lane enabled
  logic        wr_sc1;           // Write to control one
  logic        rd_go;            // Read address taken this cycle
  logic [31:0] next_rdata;       // Read data being assembled
  logic [1:0]  next_rresp;       // Read response being assembled
  logic [7:0]  sc1;              // Channel, continuous, enable
  logic [7:0]  sc2;              // Mode and clock select
  logic        flag;             // conversion_complete_flag
  logic [`ARSI_EV_WIDTH-1:0] ev_status; // Sticky events
  logic [`ARSI_EV_WIDTH-1:0] ev_mask;   // Event enables
  logic [`ARSI_EV_WIDTH-1:0] ev_set;    // Events this cycle
  logic        tgl_sync;         // Synchronised completion toggle
  logic        tgl_prev;         // Previous synchronised toggle
  logic        done_pulse;       // One completion seen
  logic [`ARSI_RESULT_WIDTH-1:0] res_sync; // Synchronised result
  logic        accept;           // Completion taken into result
  logic [1:0]  guard_cnt;        // Guard cycles left
  logic [7:0]  res_high;         // High byte view
  logic [7:0]  res_low;          // Low byte view
  logic        rd_high;          // High byte read taken
  logic        rd_low;           // Low byte read taken
  logic        start_req;        // Conversion start this cycle
  arsi_pkg::arsi_state_e state;  // Conversion control state

  // ****************************************************************
  // Engine crossing
  // ****************************************************************
  // Result is steady around each toggle flip;
  // both pass two flops here
  arsi_sync #(
    .WIDTH (1)
  ) u_sync_tgl (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (conv_done_tgl),
    .q       (tgl_sync)
  );

  arsi_sync #(
    .WIDTH (`ARSI_RESULT_WIDTH)
  ) u_sync_res (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (conv_result),
    .q       (res_sync)
  );

  // Edge of the synchronised toggle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tgl_prev <= 1'b0;
    end else begin
      tgl_prev <= tgl_sync;
    end
  end

  assign done_pulse = tgl_sync ^ tgl_prev;

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign wr_go         = aw_held && w_held && !s_axi_bvalid;
  assign wr_lane0      = wr_go && w_strb[0];
  assign wr_sc1        = wr_lane0 && (aw_addr == `ARSI_OFS_STATUS_CONTROL_ONE);

  // Address capture, independent of data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid && !aw_held) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_held <= 1'b0;
    end
  end

  // Data capture, independent of address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && !w_held) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_go) begin
      w_held <= 1'b0;
    end
  end

  // Write response, error for unmapped offsets
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `ARSI_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      case (aw_addr)
        `ARSI_OFS_STATUS_CONTROL_ONE,
        `ARSI_OFS_STATUS_CONTROL_TWO,
        `ARSI_OFS_RESULT_HIGH,
        `ARSI_OFS_RESULT_LOW,
        `ARSI_OFS_EVENT_STATUS,
        `ARSI_OFS_EVENT_MASK: s_axi_bresp <= `ARSI_RESP_OKAY;
        default:              s_axi_bresp <= `ARSI_RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  // Channel, continuous and enable bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sc1 <= `ARSI_SC1_RESET;
    end else if (wr_sc1) begin
      sc1 <= {1'b0, w_data[6:0]};
    end
  end

  // Resolution and engine clock choice
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sc2 <= `ARSI_SC2_RESET;
    end else if (wr_lane0 && (aw_addr == `ARSI_OFS_STATUS_CONTROL_TWO)) begin
      sc2 <= {5'h00, w_data[`ARSI_SC2_ACLK_BIT:0]};
    end
  end

  // Event mask
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ev_mask <= `ARSI_MASK_RESET;
    end else if (wr_lane0 && (aw_addr == `ARSI_OFS_EVENT_MASK)) begin
      ev_mask <= w_data[`ARSI_EV_WIDTH-1:0];
    end
  end

  assign conv_channel       = sc1[`ARSI_SC1_CHAN_MSB:`ARSI_SC1_CHAN_LSB];
  assign conv_mode          = sc2[`ARSI_SC2_MODE_MSB:`ARSI_SC2_MODE_LSB];
  assign conv_async_clk_sel = sc2[`ARSI_SC2_ACLK_BIT];

  // ****************************************************************
  // Conversion control
  // ****************************************************************
  // A control one write aborts and, unless the
  // channel is off, restarts; stop-then-start
  // software restarts the engine on its start write
  assign start_req = (wr_sc1 && (w_data[4:0] != `ARSI_CHAN_OFF)) ||
                     (accept && sc1[`ARSI_SC1_CONT_BIT]);
  // Completions in a write or guard cycle are stale
  assign accept    = done_pulse && !wr_sc1 && (state == arsi_pkg::ARSI_ST_CONV);

  // Engine strobes, one cycle each
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conv_start <= 1'b0;
      conv_abort <= 1'b0;
    end else begin
      conv_start <= start_req;
      conv_abort <= wr_sc1;
    end
  end

  // State of the converter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state     <= arsi_pkg::ARSI_ST_IDLE;
      guard_cnt <= 2'h0;
    end else if (wr_sc1) begin
      // Restart or stop wins over anything in flight
      guard_cnt <= `ARSI_GUARD_CYCLES;
      if (w_data[4:0] != `ARSI_CHAN_OFF) begin
        state <= arsi_pkg::ARSI_ST_GUARD;
      end else begin
        state <= arsi_pkg::ARSI_ST_IDLE;
      end
    end else begin
      case (state)
        arsi_pkg::ARSI_ST_IDLE: begin
          state <= arsi_pkg::ARSI_ST_IDLE;
        end
        arsi_pkg::ARSI_ST_GUARD: begin
          // Let stale toggles drain out of the synchroniser
          if (guard_cnt == 2'h0) begin
            state <= arsi_pkg::ARSI_ST_CONV;
          end else begin
            guard_cnt <= guard_cnt - 2'h1;
          end
        end
        arsi_pkg::ARSI_ST_CONV: begin
          if (accept && !sc1[`ARSI_SC1_CONT_BIT]) begin
            state <= arsi_pkg::ARSI_ST_IDLE;
          end else begin
            state <= arsi_pkg::ARSI_ST_CONV;
          end
        end
        default: begin
          state <= arsi_pkg::ARSI_ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Result and flag
  // ****************************************************************
  arsi_coherent u_coherent (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .load      (accept),
    .load_data (res_sync),
    .mode      (conv_mode),
    .rd_high   (rd_high),
    .rd_low    (rd_low),
    .high_byte (res_high),
    .low_byte  (res_low)
  );

  // Write beats a same-cycle completion,
  // which is dropped with its data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag <= 1'b0;
    end else if (wr_sc1) begin
      flag <= 1'b0;
    end else if (accept) begin
      flag <= 1'b1;
    end else if (rd_low || (rd_high && (conv_mode == arsi_pkg::ARSI_RES_8))) begin
      flag <= 1'b0;
    end
  end

  // ****************************************************************
  // Events and interrupt
  // ****************************************************************
  assign ev_set[`ARSI_EV_DONE_BIT]    = accept;
  assign ev_set[`ARSI_EV_OVERRUN_BIT] = accept && flag;

  // Sticky events; a same-cycle event survives its read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ev_status <= '0;
    end else if (rd_go && (s_axi_araddr == `ARSI_OFS_EVENT_STATUS)) begin
      ev_status <= ev_set;
    end else begin
      ev_status <= ev_status | ev_set;
    end
  end

  // Enabled flag or any unmasked event
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= (flag && sc1[`ARSI_SC1_IEN_BIT]) || (|(ev_status & ev_mask));
    end
  end

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_go         = s_axi_arvalid && !s_axi_rvalid;
  assign rd_high       = rd_go && (s_axi_araddr == `ARSI_OFS_RESULT_HIGH);
  assign rd_low        = rd_go && (s_axi_araddr == `ARSI_OFS_RESULT_LOW);

  // Read mux, narrow registers in the low bits
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rresp = `ARSI_RESP_OKAY;
    case (s_axi_araddr)
      `ARSI_OFS_STATUS_CONTROL_ONE: next_rdata[7:0] = {flag, sc1[6:0]};
      `ARSI_OFS_STATUS_CONTROL_TWO: begin
        next_rdata[7:0] = {state != arsi_pkg::ARSI_ST_IDLE, sc2[6:0]};
      end
      `ARSI_OFS_RESULT_HIGH:  next_rdata[7:0] = res_high;
      `ARSI_OFS_RESULT_LOW:   next_rdata[7:0] = res_low;
      `ARSI_OFS_EVENT_STATUS: next_rdata[`ARSI_EV_WIDTH-1:0] = ev_status;
      `ARSI_OFS_EVENT_MASK:   next_rdata[`ARSI_EV_WIDTH-1:0] = ev_mask;
      default:                next_rresp = `ARSI_RESP_SLVERR;
    endcase
  end

  // Read data one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `ARSI_RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : arsi_top

/* File: bench/arsi_top_monitor.sv */
`timescale 1ns/1ps
// ****************************************************************
// Port checker for the result and status block
// ****************************************************************
module arsi_top_monitor (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        conv_start,
  input wire logic        conv_abort,
  input wire logic [4:0]  conv_channel,
  input wire logic [1:0]  conv_mode,
  input wire logic        conv_async_clk_sel,
  input wire logic        irq
);
  logic [7:0]  aw_q;  // Offset of the last write
  logic [7:0]  ar_q;  // Offset of the last read
  logic [31:0] wd_q;  // Data of the last write
  logic        ws_q;  // Lane zero strobe of the last write

  // Remember what each accepted transfer carried
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 8'h00;
      ar_q <= 8'h00;
      wd_q <= 32'h0;
      ws_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) {wd_q, ws_q} <= {s_axi_wdata, s_axi_wstrb[0]};
      if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
    end
  end

  default clocking dc @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Control one write, seen as its response rises
  sequence s_wr_sc1;
    $rose(s_axi_bvalid) && aw_q == 8'h00 && ws_q;
  endsequence

  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  property p_start; conv_start |-> conv_channel != 5'h1F ##1 !conv_start; endproperty
  property p_abort; s_wr_sc1 |-> ##[0:1] conv_abort; endproperty
  property p_chan; s_wr_sc1 |-> ##[0:1] conv_channel == wd_q[4:0]; endproperty
  property p_clk;
    $rose(s_axi_bvalid) && aw_q == 8'h04 && ws_q |-> ##[0:1] conv_async_clk_sel == wd_q[2];
  endproperty
  property p_byte8;
    s_axi_rvalid && ar_q == 8'h08 && conv_mode == 2'h0 |-> s_axi_rdata == 32'h0;
  endproperty
  property p_irq; s_axi_rvalid && ar_q == 8'h00 && s_axi_rdata[7:6] == 2'h3 |-> ##[0:1] irq; endproperty

  a_bhold: assert property (p_bhold) else $error("write response dropped early");
  a_rhold: assert property (p_rhold) else $error("read data dropped early");
  a_rans: assert property (p_rans) else $error("read answer late");
  a_start: assert property (p_start) else $error("bad start strobe");
  a_abort: assert property (p_abort) else $error("no abort after control write");
  a_chan: assert property (p_chan) else $error("channel not taken");
  a_clk: assert property (p_clk) else $error("engine clock select not taken");
  a_byte8: assert property (p_byte8) else $error("high byte not zero in 8 bit mode");
  a_irq: assert property (p_irq) else $error("enabled flag without interrupt");

  c_irq: cover property ($rose(irq));
  c_start: cover property (conv_start);
  c_wr: cover property (s_wr_sc1);
endmodule : arsi_top_monitor

bind arsi_top arsi_top_monitor u_mon (.*);

/* File: bench/arsi_top_bench.sv */
`timescale 1ns/1ps
// ****************************************************************
// Bench for the result and status block
// ****************************************************************
module arsi_top_bench;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, conv_start, conv_abort, conv_async_clk_sel, conv_done_tgl, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, hi, lo, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, conv_mode;
  logic [4:0]  conv_channel;
  logic [11:0] conv_result, ra, rb, mk;  // Engine result and expected values
  int          err_total = 0, n_tests = 0, n_start = 0, s;

  arsi_top dut (.*);

  // 40 MHz clock
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // Count conversion starts
  always @(posedge aclk) if (conv_start === 1'b1) n_start <= n_start + 1;

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er = 2'h0);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(er), 32'(s_axi_bresp));
    repeat (2) @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er = 2'h0);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    v = s_axi_rdata;
    chk("rresp", 32'(er), 32'(s_axi_rresp));
  endtask : rd

  task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    chk(n, e, v);
  endtask : rc

  // Engine completion, result held around the flip
  task automatic flip(input logic [11:0] r);
    @(posedge aclk);
    conv_result <= r;
    repeat (3) @(posedge aclk);
    conv_done_tgl <= ~conv_done_tgl;
    repeat (6) @(posedge aclk);
  endtask : flip

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  // Watchdog
  initial begin
    repeat (6000) @(posedge aclk);
    err_total++;
    final_report();
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, conv_result, conv_done_tgl} = 61'h0;
    s_axi_wstrb = 4'hF;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rc("sc1 reset", 8'h00, 32'h1F);
    rc("sc2 reset", 8'h04, 32'h00);
    rc("mask reset", 8'h14, 32'h00);
    rd(8'h20, d, 2'h2);
    chk("unmapped", 32'h0, d);
    wr(8'h24, 32'hFF, 2'h2);
    wr(8'h04, 32'h5);
    chk("clk sel", 32'h1, 32'(conv_async_clk_sel));
    wr(8'h04, 32'h1);
    chk("clk sel off", 32'h0, 32'(conv_async_clk_sel));
    // Single conversion in 10-bit mode
    wr(8'h00, 32'h43);
    repeat (8) @(posedge aclk);
    s = n_start;
    flip(12'h2BC);
    chk("irq", 32'h1, 32'(irq));
    rc("flag", 8'h00, 32'hC3);
    rc("high", 8'h08, 32'h2);
    flip(12'h1FF);
    rc("high held", 8'h08, 32'h2);
    rc("low held", 8'h0C, 32'hBC);
    chk("no restart", 32'(s), 32'(n_start));
    // Stop, then select a new channel
    wr(8'h00, 32'h1F);
    chk("irq off", 32'h0, 32'(irq));
    rc("off", 8'h00, 32'h1F);
    wr(8'h00, 32'h45);
    chk("channel", 32'h5, 32'(conv_channel));
    // Continuous conversion in 10-bit and 12-bit modes
    for (int m = 1; m < 3; m++) begin
      mk = (m == 1) ? 12'h3FF : 12'hFFF;
      wr(8'h04, 32'(m));
      chk("mode", 32'(m), 32'(conv_mode));
      wr(8'h00, 32'h63);
      repeat (8) @(posedge aclk);
      s = n_start;
      ra = 12'hA5C;
      flip(ra);
      chk("restart", 32'(s + 1), 32'(n_start));
      rd(8'h08, hi);
      flip(12'h3E1);
      rd(8'h0C, lo);
      chk("frozen", 32'(ra & mk), {20'h0, hi[3:0], lo[7:0]});
      ra = 12'h3E1;
      // High read lands around the next completion
      for (int k = 4; k < 7; k++) begin
        rb = ra + 12'h123;
        fork
          flip(rb);
          begin repeat (k) @(posedge aclk); rd(8'h08, hi); end
        join
        rd(8'h0C, lo);
        d = {20'h0, hi[3:0], lo[7:0]};
        chk("coherent", 32'h1, 32'(d[11:0] == (ra & mk) || d[11:0] == (rb & mk)));
        ra = rb;
      end
      // Control write lands around a completion
      for (int k = 2; k < 5; k++) begin
        flip(12'h0F0);
        fork
          flip(12'h111);
          begin repeat (k) @(posedge aclk); wr(8'h00, 32'h63); end
        join
        rc("flag cleared", 8'h00, 32'h63);
        chk("irq cleared", 32'h0, 32'(irq));
      end
    end
    // Eight-bit result
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h43);
    repeat (8) @(posedge aclk);
    flip(12'hABC);
    rc("byte8 low", 8'h0C, 32'hAB);
    rc("byte8 high", 8'h08, 32'h00);
    rc("byte8 flag", 8'h00, 32'h43);
    // Event status, mask and read clear
    wr(8'h00, 32'h03);
    rd(8'h10, d);
    rc("event clear", 8'h10, 32'h0);
    flip(12'h777);
    chk("irq disabled", 32'h0, 32'(irq));
    wr(8'h14, 32'h1);
    chk("irq event", 32'h1, 32'(irq));
    rc("event", 8'h10, 32'h1);
    repeat (2) @(posedge aclk);
    chk("irq event off", 32'h0, 32'(irq));
    rc("mask", 8'h14, 32'h1);
    final_report();
  end
endmodule : arsi_top_bench
